// ---- rtl/cmp_pin_defines.svh ----
`ifndef CMP_PIN_DEFINES_SVH
`define CMP_PIN_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_W 10
`define IDX_PIN_DIR_A 10'h085
`define IDX_PORT_A 10'h005
`define IDX_CMP_CTRL 10'h01f
`define IDX_ANALOG_A 10'h09f

// widths
`define PIN_N 5
`define REG_W 8
`define BUS_W 32
`define MODE_W 3

// pin positions of the routed comparator outputs
`define PIN_A3 3
`define PIN_A4 4

// comparator control field positions
`define CMP_MODE_LSB 0
`define CMP_MODE_MSB 2
`define CMP_RES1_BIT 6
`define CMP_RES2_BIT 7

// comparator mode that routes results onto the pins
`define MODE_PIN_ROUTED 3'h6

// reset values
`define PIN_DIR_RST 5'h1f
`define PORT_LATCH_RST 5'h00
`define CMP_MODE_RST 3'h0
`define ANALOG_RST 5'h00
`define REG_ZERO 8'h00
`define BUS_ZERO 32'h00000000

`endif

// ---- rtl/cmp_pin_pkg.sv ----
package cmp_pin_pkg;

   // register selected by a bus address
   typedef enum {
      SEL_NONE,
      SEL_PIN_DIR,
      SEL_PORT,
      SEL_CMP_CTRL,
      SEL_ANALOG
   } reg_sel_e;

   typedef logic [4:0] pin_vec_t;
   typedef logic [2:0] cmp_mode_t;
   typedef logic [7:0] reg_byte_t;

endpackage

// ---- rtl/cmp_pin_route.sv ----
// Overview of operation
// - comparator results readable, writes to them ignored
// - mode 110 routes comparators onto pin_a3, pin_a4
// - routed pin path has no flop
// - direction bits still gate routed pin drivers
// - analog pins read zero on port read
// - direction bits 4:0, upper zero, reset ones
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none

`include "cmp_pin_defines.svh"

module cmp_pin_route (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,

   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [31:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [`BUS_W-1:0] WB_DAT_I,
   output logic [`BUS_W-1:0] WB_DAT_O,
   output logic WB_ACK_O,

   // comparator results
   input wire logic CMP1_RES,
   input wire logic CMP2_RES,

   // port pins
   input wire logic [`PIN_N-1:0] PIN_A_IN,
   output logic [`PIN_N-1:0] PIN_A_OUT,
   output logic [`PIN_N-1:0] PIN_A_OE_N
);

   // register decode, used for both read and write paths
   function automatic cmp_pin_pkg::reg_sel_e decode(input logic [`IDX_W-1:0] idx);
      cmp_pin_pkg::reg_sel_e sel;
      sel = cmp_pin_pkg::SEL_NONE;
      case (idx)
         `IDX_PIN_DIR_A: begin
            sel = cmp_pin_pkg::SEL_PIN_DIR;
         end
         `IDX_PORT_A: begin
            sel = cmp_pin_pkg::SEL_PORT;
         end
         `IDX_CMP_CTRL: begin
            sel = cmp_pin_pkg::SEL_CMP_CTRL;
         end
         `IDX_ANALOG_A: begin
            sel = cmp_pin_pkg::SEL_ANALOG;
         end
         default: begin
            sel = cmp_pin_pkg::SEL_NONE;
         end
      endcase
      return sel;
   endfunction

   // register state
   cmp_pin_pkg::pin_vec_t dir_q;
   cmp_pin_pkg::pin_vec_t dir_d;
   cmp_pin_pkg::pin_vec_t latch_q;
   cmp_pin_pkg::pin_vec_t latch_d;
   cmp_pin_pkg::cmp_mode_t mode_q;
   cmp_pin_pkg::cmp_mode_t mode_d;
   cmp_pin_pkg::pin_vec_t analog_q;
   cmp_pin_pkg::pin_vec_t analog_d;

   // bus state
   logic ack_q;
   logic ack_d;
   logic [`BUS_W-1:0] rdata_q;
   logic [`BUS_W-1:0] rdata_d;

   // bus decode
   wire logic [`IDX_W-1:0] idx;
   wire logic req;
   wire logic wr_en;
   wire logic rd_en;
   // an int-based enum is two-state and cannot be a net
   cmp_pin_pkg::reg_sel_e sel;
   wire logic wr_dir;
   wire logic wr_port;
   wire logic wr_cmp;
   wire logic wr_analog;
   wire cmp_pin_pkg::reg_byte_t wbyte;

   assign idx = WB_ADR_I[`IDX_W+1:2];
   assign req = WB_CYC_I & WB_STB_I & ~ack_q;
   // only byte lane 0 carries data; other lanes are ignored
   assign wr_en = req & WB_WE_I & WB_SEL_I[0];
   assign rd_en = req & ~WB_WE_I;
   assign sel = decode(idx);
   assign wr_dir = wr_en & (sel == cmp_pin_pkg::SEL_PIN_DIR);
   assign wr_port = wr_en & (sel == cmp_pin_pkg::SEL_PORT);
   assign wr_cmp = wr_en & (sel == cmp_pin_pkg::SEL_CMP_CTRL);
   assign wr_analog = wr_en & (sel == cmp_pin_pkg::SEL_ANALOG);
   assign wbyte = WB_DAT_I[`REG_W-1:0];

   // next register values
   assign dir_d = wr_dir ? wbyte[`PIN_N-1:0] : dir_q;
   assign latch_d = wr_port ? wbyte[`PIN_N-1:0] : latch_q;
   // result bits are not storage, so a write can only change the mode
   assign mode_d = wr_cmp ? wbyte[`CMP_MODE_MSB:`CMP_MODE_LSB] : mode_q;
   assign analog_d = wr_analog ? wbyte[`PIN_N-1:0] : analog_q;

   // read views
   wire cmp_pin_pkg::reg_byte_t dir_view;
   wire cmp_pin_pkg::reg_byte_t cmp_view;
   wire cmp_pin_pkg::reg_byte_t analog_view;
   wire cmp_pin_pkg::reg_byte_t port_view;
   wire cmp_pin_pkg::reg_byte_t read_byte;

   // bits 7:5 have no storage and read zero
   assign dir_view = {{(`REG_W-`PIN_N){1'b0}}, dir_q};
   assign analog_view = {{(`REG_W-`PIN_N){1'b0}}, analog_q};
   // live comparator levels, sampled only into read data
   assign cmp_view = {CMP2_RES, CMP1_RES, 3'h0, mode_q};

   port_read_mask u_port_mask (
      .pin_level(PIN_A_IN),
      .analog_sel(analog_q),
      .port_value(port_view)
   );

   assign read_byte = (sel == cmp_pin_pkg::SEL_PIN_DIR) ? dir_view :
                      (sel == cmp_pin_pkg::SEL_PORT) ? port_view :
                      (sel == cmp_pin_pkg::SEL_CMP_CTRL) ? cmp_view :
                      (sel == cmp_pin_pkg::SEL_ANALOG) ? analog_view :
                      `REG_ZERO;

   // a read only loads rdata; no register state depends on rd_en
   assign rdata_d = rd_en ? {{(`BUS_W-`REG_W){1'b0}}, read_byte} : rdata_q;
   // one ack per request, mapped or not; unmapped reads return zero
   assign ack_d = req;

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         dir_q <= `PIN_DIR_RST;
         latch_q <= `PORT_LATCH_RST;
         mode_q <= `CMP_MODE_RST;
         analog_q <= `ANALOG_RST;
      end else begin
         dir_q <= dir_d;
         latch_q <= latch_d;
         mode_q <= mode_d;
         analog_q <= analog_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         ack_q <= 1'b0;
         rdata_q <= `BUS_ZERO;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdata_q;

   // pin output path
   wire logic routed;

   assign routed = (mode_q == `MODE_PIN_ROUTED);

   // comparator results reach the pins combinationally; only that path skips a flop
   pin_out_mux u_out_mux (
      .routed(routed),
      .latch(latch_q),
      .cmp1_res(CMP1_RES),
      .cmp2_res(CMP2_RES),
      .pin_out(PIN_A_OUT)
   );

   // a set direction bit keeps the driver off in every mode, routed or not;
   // software must clear bits 4:3 itself before the comparators can show
   assign PIN_A_OE_N = dir_q;

endmodule

`default_nettype wire

// ---- rtl/pin_out_mux.sv ----
`timescale 1ns/1ns
`default_nettype none

`include "cmp_pin_defines.svh"

module pin_out_mux (
   // mode
   input wire logic routed,
   // sources
   input wire cmp_pin_pkg::pin_vec_t latch,
   input wire logic cmp1_res,
   input wire logic cmp2_res,
   // pin drive
   output logic [`PIN_N-1:0] pin_out
);

   // comparator results pass with no flop: the pin follows the comparator at once
   genvar i;
   generate
      for (i = 0; i < `PIN_N; i = i + 1) begin : g_pin
         if (i == `PIN_A3) begin : g_a3
            assign pin_out[i] = routed ? cmp1_res : latch[i];
         end else if (i == `PIN_A4) begin : g_a4
            assign pin_out[i] = routed ? cmp2_res : latch[i];
         end else begin : g_plain
            assign pin_out[i] = latch[i];
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ---- rtl/port_read_mask.sv ----
`timescale 1ns/1ns
`default_nettype none

`include "cmp_pin_defines.svh"

module port_read_mask (
   // pin levels and analog selection
   input wire cmp_pin_pkg::pin_vec_t pin_level,
   input wire cmp_pin_pkg::pin_vec_t analog_sel,
   // masked value
   output cmp_pin_pkg::reg_byte_t port_value
);

   wire cmp_pin_pkg::pin_vec_t masked;

   genvar i;
   generate
      for (i = 0; i < `PIN_N; i = i + 1) begin : g_bit
         // analog pins read zero whatever level sits on them
         assign masked[i] = pin_level[i] & ~analog_sel[i];
      end
   endgenerate

   assign port_value = {{(`REG_W-`PIN_N){1'b0}}, masked};

endmodule

`default_nettype wire

// ---- tb/cmp_pin_route_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module cmp_pin_route_bench;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, c1 = 1, c2 = 0, ack;
   logic [31:0] adr = '0, dat = '0, rd, lf = 32'h7819;
   logic [3:0] sel = 4'h1;
   logic [4:0] pout, oen, pin, ext = '0;
   logic [7:0] expq[$];
   int n_mismatch = 0, checked = 0, k;
   cmp_pin_route cmp_pin_route_i (.CORE_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rd), .WB_ACK_O(ack),
      .CMP1_RES(c1), .CMP2_RES(c2), .PIN_A_IN(pin), .PIN_A_OUT(pout), .PIN_A_OE_N(oen));
   pin_load pin_load_i (.drive(pout), .oe_n(oen), .ext(ext), .level(pin));
   initial forever #20 clk = ~clk;
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // automatic: the read monitor and the main flow may both call it
   task automatic chk(input string nm, input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task wb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= {20'h0, a}; dat <= {24'h0, d};
      for (i = 0; i < 20 && !ack; i++) @(posedge clk);
      if (!ack) begin
         chk("bus ack", 8'h01, 8'h00);
         wrap_up;
      end
      cyc <= 0; stb <= 0;
   endtask
   task rd_chk(input logic [11:0] a, input logic [7:0] e);
      expq.push_back(e);
      wb(0, a, 8'h00);
   endtask
   // empty queue yields x, so a stray ack never matches
   always @(posedge clk)
      if (ack && !we)
         chk("read data", expq.size() ? expq.pop_front() : 8'hxx, rd[7:0]);
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1;
      rd_chk(12'h214, 8'h1f);
      wb(1, 12'h214, 8'hff);
      rd_chk(12'h214, 8'h1f);
      $display("test direction done");
      wb(1, 12'h07c, 8'hc6);
      rd_chk(12'h07c, 8'h46);
      chk("enable", 8'h1f, {3'h0, oen});
      wb(1, 12'h214, 8'h07);
      #1 chk("enable", 8'h07, {3'h0, oen});
      for (k = 0; k < 8; k++) begin
         @(posedge clk);
         lf = lfsr_next(lf);
         c1 <= lf[0]; c2 <= lf[1]; ext <= lf[6:2];
         #1 chk("routed pins", {lf[1], lf[0]}, pout[4:3]);
      end
      $display("test routing done");
      wb(1, 12'h27c, 8'h0d);
      rd_chk(12'h014, {3'h0, c2, c1, ext[2:0]} & 8'hf2);
      wb(1, 12'h07c, 8'h00);
      wb(1, 12'h014, 8'h1b);
      #1 chk("latch out", 8'h1b, {3'h0, pout});
      @(posedge clk) sel <= 4'h0;
      wb(1, 12'h214, 8'h00);
      sel <= 4'h1;
      rd_chk(12'h214, 8'h07);
      rd_chk(12'h3f0, 8'h00);
      $display("test port done");
      @(posedge clk);
      wrap_up;
   end
endmodule
`default_nettype wire

// ---- tb/cmp_pin_route_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module cmp_pin_route_sva (
   input wire logic CORE_CLK, RESETN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, CMP1_RES, CMP2_RES,
   input wire logic [31:0] WB_ADR_I, WB_DAT_I, WB_DAT_O,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [4:0] PIN_A_IN, PIN_A_OUT, PIN_A_OE_N
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   logic [2:0] mode_q;
   logic [4:0] an_q;
   wire tk = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   wire [9:0] ix = WB_ADR_I[11:2];
   wire wr_ok = tk && WB_WE_I && WB_SEL_I[0];
   wire wr_dir = wr_ok && ix == 10'h085;
   // routed pins follow the comparators, so they may move during a read
   wire routed = mode_q == 3'h6;
   // shadow copies, the checker cannot see inside
   always_ff @(posedge CORE_CLK)
      mode_q <= !RESETN ? 3'h0 : wr_ok && ix == 10'h01f ? WB_DAT_I[2:0] : mode_q;
   always_ff @(posedge CORE_CLK)
      an_q <= !RESETN ? 5'h0 : wr_ok && ix == 10'h09f ? WB_DAT_I[4:0] : an_q;
   sequence rd_of(logic [9:0] r);
      tk && !WB_WE_I && ix == r ##1 WB_ACK_O;
   endsequence
   ack_one_a: assert property (tk |=> WB_ACK_O ##1 !WB_ACK_O) else $error("ack not one pulse");
   res_read_a: assert property (rd_of(10'h01f) |->
      WB_DAT_O[7:6] == {$past(CMP2_RES), $past(CMP1_RES)}) else $error("result bits wrong");
   route_a: assert property (mode_q == 3'h6 |-> PIN_A_OUT[4:3] == {CMP2_RES, CMP1_RES})
      else $error("routed pins wrong");
   oe_hold_a: assert property ($changed(PIN_A_OE_N) && $past(RESETN) |-> $past(wr_dir))
      else $error("enable moved without write");
   dir_rst_a: assert property ($rose(RESETN) |-> PIN_A_OE_N == 5'h1f)
      else $error("enable reset");
   dir_top_a: assert property (rd_of(10'h085) |-> WB_DAT_O[7:5] == 3'h0)
      else $error("dir top bits");
   port_mask_a: assert property (rd_of(10'h005) |->
      WB_DAT_O[7:0] == {3'h0, $past(PIN_A_IN) & ~an_q}) else $error("port read mask");
   read_quiet_a: assert property (tk && !WB_WE_I |=> $stable(PIN_A_OE_N) &&
      $stable(PIN_A_OUT[2:0]) && (routed || $stable(PIN_A_OUT[4:3])))
      else $error("read changed pins");
   dat_top_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
      else $error("read top bits");
endmodule
bind cmp_pin_route cmp_pin_route_sva cmp_pin_route_sva_i (.*);
`default_nettype wire

// ---- tb/pin_load.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_load (
   // pad side of the block
   input wire logic [4:0] drive,
   input wire logic [4:0] oe_n,
   // board level where undriven, changed by the bench at each step of its routing loop only
   input wire logic [4:0] ext,
   output logic [4:0] level
);
   assign level = (drive & ~oe_n) | (ext & oe_n);
endmodule
`default_nettype wire
